// file: pad_model.sv
`timescale 1ns/1ps
module pad_model #(
	parameter int W = 8
) (
	// block side of the pads
	input wire logic [W-1:0] out,
	input wire logic [W-1:0] oe,
	// far-side drive
	input wire logic [W-1:0] drv,
	output logic [W-1:0] pin
);
	// ----------------------------------------
	// wire level
	// ----------------------------------------
	// far side always drives, so a weak pull-up never decides the level
	always_comb begin
		for (int i = 0; i < W; i++) begin
			pin[i] = oe[i] ? out[i] : drv[i];
		end
	end
endmodule : pad_model

// file: pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
	parameter int W = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// pins
	input wire logic [W-1:0] pin_in,
	output logic [W-1:0] level
);
	logic [W-1:0] s1_reg;
	logic [W-1:0] s2_reg;
	logic [W-1:0] s3_reg;
	logic [W-1:0] level_reg;
	logic [W-1:0] level_next;

	// a change counts once stages two and three agree
	genvar i;
	for (i = 0; i < W; i++) begin : g_bit
		always_comb begin
			level_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : level_reg[i];
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
			level_reg <= '0;
		end else begin
			s1_reg <= pin_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			level_reg <= level_next;
		end
	end

	assign level = level_reg;
endmodule : pin_sync

// file: port_ctl.sv
`timescale 1ns/1ps
`include "port_ctl_params.svh"
module port_ctl
	import port_ctl_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// pin inputs
	input wire logic [7:0] port_a_in,
	input wire logic [7:0] port_b_in,
	input wire logic [7:0] port_c_in,
	input wire logic [4:0] port_g_in,
	// external memory strobes
	input wire logic mem_ale,
	input wire logic mem_rd,
	input wire logic mem_wr,
	// port a pads
	output logic [7:0] port_a_out,
	output logic [7:0] port_a_oe,
	output logic [7:0] port_a_pullup,
	// port b pads
	output logic [7:0] port_b_out,
	output logic [7:0] port_b_oe,
	output logic [7:0] port_b_pullup,
	// port c pads
	output logic [7:0] port_c_out,
	output logic [7:0] port_c_oe,
	output logic [7:0] port_c_pullup,
	// port g pads
	output logic [4:0] port_g_out,
	output logic [4:0] port_g_oe,
	output logic [4:0] port_g_pullup,
	output logic [4:0] port_g_input_en,
	output logic osc_pins_attached
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	byte_t a_out_reg, a_out_next, a_dir_reg, a_dir_next;
	byte_t b_out_reg, b_out_next, b_dir_reg, b_dir_next;
	byte_t c_out_reg, c_out_next, c_dir_reg, c_dir_next;
	gbits_t g_out_reg, g_out_next, g_dir_reg, g_dir_next;
	logic [`CTRL_WIDTH-1:0] ctrl_reg, ctrl_next;
	logic pready_reg, pready_next, pslverr_reg, pslverr_next;
	logic [31:0] prdata_reg, prdata_next;
	byte_t a_lvl, b_lvl, c_lvl;
	gbits_t g_lvl;
	reg_sel_t sel;
	logic wr_en;
	logic async_sel, extclk_sel, mem_en;

	byte_t pa_out_reg, pa_out_next, pa_oe_reg, pa_oe_next, pa_pu_reg, pa_pu_next;
	byte_t pb_out_reg, pb_out_next, pb_oe_reg, pb_oe_next, pb_pu_reg, pb_pu_next;
	byte_t pc_out_reg, pc_out_next, pc_oe_reg, pc_oe_next, pc_pu_reg, pc_pu_next;
	gbits_t pg_out_reg, pg_out_next, pg_oe_reg, pg_oe_next, pg_pu_reg, pg_pu_next;
	gbits_t pg_ien_reg, pg_ien_next;
	logic osc_reg, osc_next;
	logic [2:0] strobes;

	assign async_sel = ctrl_reg[`CTRL_ASYNC_BIT];
	assign extclk_sel = ctrl_reg[`CTRL_EXTCLK_BIT];
	assign mem_en = ctrl_reg[`CTRL_MEM_BIT];
	assign strobes = {mem_ale, mem_rd, mem_wr};

	// ----------------------------------------
	// pin sampling
	// ----------------------------------------
	// one synchroniser for all 29 pins keeps their samples aligned
	pin_sync #(.W(29)) u_sync (
		.clk(clk),
		.resetn(resetn),
		.pin_in({port_g_in, port_c_in, port_b_in, port_a_in}),
		.level({g_lvl, c_lvl, b_lvl, a_lvl})
	);

	// ----------------------------------------
	// apb decode
	// ----------------------------------------
	always_comb begin
		case (paddr)
			`OFS_A_OUT: sel = SEL_A_OUT;
			`OFS_A_DIR: sel = SEL_A_DIR;
			`OFS_A_PIN: sel = SEL_A_PIN;
			`OFS_B_OUT: sel = SEL_B_OUT;
			`OFS_B_DIR: sel = SEL_B_DIR;
			`OFS_B_PIN: sel = SEL_B_PIN;
			`OFS_C_OUT: sel = SEL_C_OUT;
			`OFS_C_DIR: sel = SEL_C_DIR;
			`OFS_C_PIN: sel = SEL_C_PIN;
			`OFS_G_OUT: sel = SEL_G_OUT;
			`OFS_G_DIR: sel = SEL_G_DIR;
			`OFS_G_PIN: sel = SEL_G_PIN;
			`OFS_CTRL: sel = SEL_CTRL;
			default: sel = SEL_NONE;
		endcase
	end

	// writes land only on the completing edge
	assign wr_en = psel & penable & pready_reg & pwrite & (sel != SEL_NONE);

	// ----------------------------------------
	// bus answer
	// ----------------------------------------
	// one wait state gives read data a full cycle to settle
	always_comb begin
		pready_next = psel & penable & ~pready_reg;
		pslverr_next = psel & penable & ~pready_reg & (sel == SEL_NONE);
		prdata_next = prdata_reg;
		if (psel & penable & ~pready_reg) begin
			case (sel)
				SEL_A_OUT: prdata_next = {24'h000000, a_out_reg};
				SEL_A_DIR: prdata_next = {24'h000000, a_dir_reg};
				SEL_A_PIN: prdata_next = {24'h000000, a_lvl};
				SEL_B_OUT: prdata_next = {24'h000000, b_out_reg};
				SEL_B_DIR: prdata_next = {24'h000000, b_dir_reg};
				SEL_B_PIN: prdata_next = {24'h000000, b_lvl};
				SEL_C_OUT: prdata_next = {24'h000000, c_out_reg};
				SEL_C_DIR: prdata_next = {24'h000000, c_dir_reg};
				SEL_C_PIN: prdata_next = {24'h000000, c_lvl};
				SEL_G_OUT: prdata_next = {27'h0000000, g_out_reg};
				SEL_G_DIR: prdata_next = {27'h0000000, g_dir_reg};
				SEL_G_PIN: prdata_next = {27'h0000000, g_lvl & pg_ien_reg};
				SEL_CTRL: prdata_next = {29'h00000000, ctrl_reg};
				default: prdata_next = 32'h00000000;
			endcase
		end
	end

	// ----------------------------------------
	// software registers
	// ----------------------------------------
	// writing ones to a pin-level register toggles the matching latch bits
	always_comb begin
		a_out_next = a_out_reg;
		a_dir_next = a_dir_reg;
		b_out_next = b_out_reg;
		b_dir_next = b_dir_reg;
		c_out_next = c_out_reg;
		c_dir_next = c_dir_reg;
		g_out_next = g_out_reg;
		g_dir_next = g_dir_reg;
		ctrl_next = ctrl_reg;
		if (wr_en) begin
			case (sel)
				SEL_A_OUT: a_out_next = pwdata[7:0];
				SEL_A_DIR: a_dir_next = pwdata[7:0];
				SEL_A_PIN: a_out_next = a_out_reg ^ pwdata[7:0];
				SEL_B_OUT: b_out_next = pwdata[7:0];
				SEL_B_DIR: b_dir_next = pwdata[7:0];
				SEL_B_PIN: b_out_next = b_out_reg ^ pwdata[7:0];
				SEL_C_OUT: c_out_next = pwdata[7:0];
				SEL_C_DIR: c_dir_next = pwdata[7:0];
				SEL_C_PIN: c_out_next = c_out_reg ^ pwdata[7:0];
				SEL_G_OUT: g_out_next = pwdata[4:0];
				SEL_G_DIR: g_dir_next = pwdata[4:0];
				SEL_G_PIN: g_out_next = g_out_reg ^ pwdata[4:0];
				SEL_CTRL: ctrl_next = pwdata[`CTRL_WIDTH-1:0];
				default: ctrl_next = ctrl_reg;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			a_out_reg <= `PORT_RESET;
			a_dir_reg <= `PORT_RESET;
			b_out_reg <= `PORT_RESET;
			b_dir_reg <= `PORT_RESET;
			c_out_reg <= `PORT_RESET;
			c_dir_reg <= `PORT_RESET;
			g_out_reg <= `G_RESET;
			g_dir_reg <= `G_RESET;
			ctrl_reg <= `CTRL_RESET;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h00000000;
		end else begin
			a_out_reg <= a_out_next;
			a_dir_reg <= a_dir_next;
			b_out_reg <= b_out_next;
			b_dir_reg <= b_dir_next;
			c_out_reg <= c_out_next;
			c_dir_reg <= c_dir_next;
			g_out_reg <= g_out_next;
			g_dir_reg <= g_dir_next;
			ctrl_reg <= ctrl_next;
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
			prdata_reg <= prdata_next;
		end
	end

	// ----------------------------------------
	// pad control
	// ----------------------------------------
	always_comb begin
		// plain ports: pull-up only on an input with its latch bit set
		pa_out_next = a_out_reg;
		pa_oe_next = a_dir_reg;
		pa_pu_next = ~a_dir_reg & a_out_reg;
		pb_out_next = b_out_reg;
		pb_oe_next = b_dir_reg;
		pb_pu_next = ~b_dir_reg & b_out_reg;
		pc_out_next = c_out_reg;
		pc_oe_next = c_dir_reg;
		pc_pu_next = ~c_dir_reg & c_out_reg;
		pg_out_next = g_out_reg;
		pg_oe_next = g_dir_reg;
		pg_pu_next = ~g_dir_reg & g_out_reg;
		pg_ien_next = 5'h1F;
		osc_next = async_sel;
		if (async_sel) begin
			pg_pu_next[`BIT_OSC_IN] = 1'b0;
			pg_oe_next[`BIT_OSC_IN] = 1'b0;
			pg_ien_next[`BIT_OSC_IN] = extclk_sel;
			pg_ien_next[`BIT_OSC_OUT] = 1'b0;
		end
		// the output pad is only released when an external clock feeds the input
		if (async_sel & extclk_sel) begin
			pg_pu_next[`BIT_OSC_OUT] = 1'b0;
			pg_oe_next[`BIT_OSC_OUT] = 1'b0;
		end
		if (mem_en) begin
			for (int i = 0; i < 3; i++) begin
				pg_pu_next[i] = 1'b0;
				pg_oe_next[i] = 1'b1;
				pg_out_next[i] = strobes[i];
			end
		end
	end

	// one register stage; strobes reach the pads one clock late
	always_ff @(posedge clk) begin
		if (!resetn) begin
			pa_out_reg <= 8'h00;
			pa_oe_reg <= 8'h00;
			pa_pu_reg <= 8'h00;
			pb_out_reg <= 8'h00;
			pb_oe_reg <= 8'h00;
			pb_pu_reg <= 8'h00;
			pc_out_reg <= 8'h00;
			pc_oe_reg <= 8'h00;
			pc_pu_reg <= 8'h00;
			pg_out_reg <= 5'h00;
			pg_oe_reg <= 5'h00;
			pg_pu_reg <= 5'h00;
			pg_ien_reg <= `G_IEN_RESET;
			osc_reg <= 1'b0;
		end else begin
			pa_out_reg <= pa_out_next;
			pa_oe_reg <= pa_oe_next;
			pa_pu_reg <= pa_pu_next;
			pb_out_reg <= pb_out_next;
			pb_oe_reg <= pb_oe_next;
			pb_pu_reg <= pb_pu_next;
			pc_out_reg <= pc_out_next;
			pc_oe_reg <= pc_oe_next;
			pc_pu_reg <= pc_pu_next;
			pg_out_reg <= pg_out_next;
			pg_oe_reg <= pg_oe_next;
			pg_pu_reg <= pg_pu_next;
			pg_ien_reg <= pg_ien_next;
			osc_reg <= osc_next;
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign port_a_out = pa_out_reg;
	assign port_a_oe = pa_oe_reg;
	assign port_a_pullup = pa_pu_reg;
	assign port_b_out = pb_out_reg;
	assign port_b_oe = pb_oe_reg;
	assign port_b_pullup = pb_pu_reg;
	assign port_c_out = pc_out_reg;
	assign port_c_oe = pc_oe_reg;
	assign port_c_pullup = pc_pu_reg;
	assign port_g_out = pg_out_reg;
	assign port_g_oe = pg_oe_reg;
	assign port_g_pullup = pg_pu_reg;
	assign port_g_input_en = pg_ien_reg;
	assign osc_pins_attached = osc_reg;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_osc_in_detach: assert property (@(posedge clk) disable iff (!resetn)
		async_sel |=> !port_g_oe[4] && !port_g_pullup[4] && osc_pins_attached)
		else $error("oscillator input pin still under port control");

	a_osc_in_gate: assert property (@(posedge clk) disable iff (!resetn)
		async_sel |=> port_g_input_en[4] == $past(extclk_sel))
		else $error("oscillator input gate does not follow external clock select");

	a_osc_out_detach: assert property (@(posedge clk) disable iff (!resetn)
		(async_sel && extclk_sel) |=> !port_g_oe[3] && !port_g_pullup[3])
		else $error("oscillator output pin still driven");

	a_osc_out_gate: assert property (@(posedge clk) disable iff (!resetn)
		async_sel |=> !port_g_input_en[3])
		else $error("oscillator output input gate not closed");

	a_ale_route: assert property (@(posedge clk) disable iff (!resetn)
		mem_en |=> port_g_oe[2] && !port_g_pullup[2] && port_g_out[2] == $past(mem_ale))
		else $error("address latch strobe not on pin");

	a_rd_route: assert property (@(posedge clk) disable iff (!resetn)
		mem_en |=> port_g_oe[1] && port_g_out[1] == $past(mem_rd))
		else $error("read strobe not on pin");

	a_wr_route: assert property (@(posedge clk) disable iff (!resetn)
		mem_en |=> port_g_oe[0] && port_g_out[0] == $past(mem_wr))
		else $error("write strobe not on pin");

	a_latch_write: assert property (@(posedge clk) disable iff (!resetn)
		(wr_en && sel == SEL_A_OUT) |=> ##1 port_a_out == $past(pwdata[7:0], 2))
		else $error("port a latch write did not reach pad");

	a_dir_reset: assert property (@(posedge clk)
		!resetn |=> a_dir_reg == 8'h00 && b_dir_reg == 8'h00 && c_dir_reg == 8'h00)
		else $error("direction register not cleared by reset");

	a_b_mirror: assert property (@(posedge clk) disable iff (!resetn)
		(wr_en && sel == SEL_B_DIR) |=> ##1 port_b_oe == $past(pwdata[7:0], 2))
		else $error("port b direction write did not reach pad");

	a_normal_path: assert property (@(posedge clk) disable iff (!resetn)
		(!mem_en && !async_sel) |=> port_g_oe == $past(g_dir_reg) && port_g_out == $past(g_out_reg))
		else $error("port g pad not from registers without override");

	c_async_mode: cover property (@(posedge clk) disable iff (!resetn) async_sel && extclk_sel);
	c_mem_mode: cover property (@(posedge clk) disable iff (!resetn) mem_en && mem_ale);
	c_pin_toggle: cover property (@(posedge clk) disable iff (!resetn) wr_en && sel == SEL_A_PIN);
	c_bad_addr: cover property (@(posedge clk) disable iff (!resetn) pready && pslverr);
endmodule : port_ctl

// file: port_ctl_params.svh
`ifndef PORT_CTL_PARAMS_SVH
`define PORT_CTL_PARAMS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_A_OUT 8'h00
`define OFS_A_DIR 8'h04
`define OFS_A_PIN 8'h08
`define OFS_B_OUT 8'h0C
`define OFS_B_DIR 8'h10
`define OFS_B_PIN 8'h14
`define OFS_C_OUT 8'h18
`define OFS_C_DIR 8'h1C
`define OFS_C_PIN 8'h20
`define OFS_G_OUT 8'h24
`define OFS_G_DIR 8'h28
`define OFS_G_PIN 8'h2C
`define OFS_CTRL 8'h30

// ----------------------------------------
// control fields and reset values
// ----------------------------------------
`define CTRL_ASYNC_BIT 0
`define CTRL_EXTCLK_BIT 1
`define CTRL_MEM_BIT 2
`define CTRL_WIDTH 3
`define PORT_WIDTH 8
`define G_WIDTH 5
`define PORT_RESET 8'h00
`define G_RESET 5'h00
`define CTRL_RESET 3'h0
`define G_IEN_RESET 5'h1F
`define BIT_OSC_IN 4
`define BIT_OSC_OUT 3
`define BIT_ALE 2
`define BIT_RD 1
`define BIT_WR 0

`endif

// file: port_ctl_pkg.sv
package port_ctl_pkg;
	typedef logic [7:0] byte_t;
	typedef logic [4:0] gbits_t;
	typedef enum logic [3:0] {
		SEL_NONE = 4'h0,
		SEL_A_OUT = 4'h1,
		SEL_A_DIR = 4'h2,
		SEL_A_PIN = 4'h3,
		SEL_B_OUT = 4'h4,
		SEL_B_DIR = 4'h5,
		SEL_B_PIN = 4'h6,
		SEL_C_OUT = 4'h7,
		SEL_C_DIR = 4'h8,
		SEL_C_PIN = 4'h9,
		SEL_G_OUT = 4'hA,
		SEL_G_DIR = 4'hB,
		SEL_G_PIN = 4'hC,
		SEL_CTRL = 4'hD
	} reg_sel_t;
endpackage : port_ctl_pkg

// file: tb_top.sv
`timescale 1ns/1ps
`include "port_ctl_params.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
	$display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module tb_top
	import port_ctl_pkg::*;
;
	typedef struct {string nm; logic rd; logic [31:0] d; logic err;} note_t;
	note_t notes[$];
	int n_errors = 0;
	int n_tests = 0;
	int cyc = 0;
	int seed;
	logic clk;
	logic resetn = 0;
	logic psel = 0;
	logic penable = 0;
	logic pwrite = 0;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0;
	logic [31:0] prdata;
	logic pready, pslverr, osc;
	logic mem_ale = 0;
	logic mem_rd = 0;
	logic mem_wr = 0;
	logic [2:0][7:0] p_out, p_oe, p_pu, p_in;
	logic [2:0][7:0] drv = 0;
	logic [4:0] g_out, g_oe, g_pu, g_ie, g_in;
	logic [4:0] g_drv = 0;
	logic [7:0] o, dr, t, dv, base;
	logic [2:0] s;

	// ----------------------------------------
	// clock, design and pads
	// ----------------------------------------
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	port_ctl dut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.port_a_in(p_in[0]), .port_b_in(p_in[1]), .port_c_in(p_in[2]), .port_g_in(g_in),
		.mem_ale(mem_ale), .mem_rd(mem_rd), .mem_wr(mem_wr),
		.port_a_out(p_out[0]), .port_a_oe(p_oe[0]), .port_a_pullup(p_pu[0]),
		.port_b_out(p_out[1]), .port_b_oe(p_oe[1]), .port_b_pullup(p_pu[1]),
		.port_c_out(p_out[2]), .port_c_oe(p_oe[2]), .port_c_pullup(p_pu[2]),
		.port_g_out(g_out), .port_g_oe(g_oe), .port_g_pullup(g_pu), .port_g_input_en(g_ie),
		.osc_pins_attached(osc));
	for (genvar i = 0; i < 3; i++) begin : g_pad
		pad_model #(.W(8)) u_pad (.out(p_out[i]), .oe(p_oe[i]), .drv(drv[i]), .pin(p_in[i]));
	end
	pad_model #(.W(5)) u_gpad (.out(g_out), .oe(g_oe), .drv(g_drv), .pin(g_in));

	// ----------------------------------------
	// bus master and result watcher
	// ----------------------------------------
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input string nm, input logic err);
		notes.push_back('{nm, !w, d, err});
		@(posedge clk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		psel <= 0;
		penable <= 0;
	endtask : apb

	always @(posedge clk) begin : watch
		note_t n;
		if (psel && penable && pready === 1'b1) begin
			if (notes.size() == 0) begin
				n_errors++;
				$display("ERROR unexpected transfer");
			end else begin
				n = notes.pop_front();
				if (n.rd) `CHK(n.nm, n.d, prdata)
				`CHK(n.nm, n.err, pslverr)
			end
		end
	end

	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			print_verdict;
		end
	end

	task print_verdict;
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : print_verdict

	task g_case(input logic [4:0] gd, input logic [2:0] ctl, input logic [4:0] oe, pu, ie, gout);
		apb(1, `OFS_G_DIR, gd, "g dir wr", 0);
		apb(1, `OFS_CTRL, ctl, "ctrl wr", 0);
		repeat (2) @(posedge clk);
		#1;
		`CHK("g oe", oe, g_oe)
		`CHK("g pullup", pu, g_pu)
		`CHK("g input en", ie, g_ie)
		`CHK("g out", gout, g_out)
		`CHK("osc attached", ctl[`CTRL_ASYNC_BIT], osc)
		repeat (4) @(posedge clk);
		apb(0, `OFS_G_PIN, 5'(((oe & gout) | ~oe) & ie), "g pin rd", 0);
	endtask : g_case

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		seed = $urandom(7675);
		// one synchronous reset edge clears every stage; two give margin
		repeat (2) @(posedge clk);
		resetn <= 1;
		@(posedge clk);
		#1;
		`CHK("g input en reset", 5'h1F, g_ie)
		`CHK("a oe reset", 8'h00, p_oe[0])
		for (int p = 0; p < 3; p++) begin
			base = `OFS_A_OUT + 8'(12 * p);
			apb(0, base, 0, "out reset", 0);
			apb(0, base + 8'h04, 0, "dir reset", 0);
		end
		$display("test reset done");
		for (int p = 0; p < 3; p++) begin
			base = `OFS_A_OUT + 8'(12 * p);
			o = 8'($urandom);
			dr = 8'($urandom);
			t = 8'($urandom);
			dv = 8'($urandom);
			drv[p] <= dv;
			apb(1, base, o, "out wr", 0);
			apb(1, base + 8'h04, dr, "dir wr", 0);
			apb(0, base, o, "out rd", 0);
			apb(0, base + 8'h04, dr, "dir rd", 0);
			repeat (2) @(posedge clk);
			#1;
			`CHK("pad out", o, p_out[p])
			`CHK("pad oe", dr, p_oe[p])
			`CHK("pad pullup", 8'(~dr & o), p_pu[p])
			apb(1, base + 8'h08, t, "pin wr", 0);
			o = o ^ t;
			apb(0, base, o, "toggled out", 0);
			repeat (6) @(posedge clk);
			apb(0, base + 8'h08, 8'((dr & o) | (~dr & dv)), "pin rd", 0);
		end
		$display("test registers and pads done");
		resetn <= 0;
		repeat (2) @(posedge clk);
		resetn <= 1;
		@(posedge clk);
		apb(0, `OFS_A_OUT, 0, "out after reset", 0);
		apb(0, `OFS_B_DIR, 0, "dir after reset", 0);
		$display("test second reset done");
		apb(0, 8'h34, 0, "unmapped rd", 1);
		apb(1, 8'h34, 32'hFF, "unmapped wr", 1);
		$display("test unmapped done");
		// far side pulls undriven g pins high so a closed input gate shows as 0
		g_drv <= 5'h1F;
		apb(1, `OFS_G_OUT, 32'h1F, "g out wr", 0);
		g_case(5'h1D, 3'h0, 5'h1D, 5'h02, 5'h1F, 5'h1F);
		g_case(5'h15, 3'h1, 5'h05, 5'h0A, 5'h07, 5'h1F);
		g_case(5'h15, 3'h3, 5'h05, 5'h02, 5'h17, 5'h1F);
		g_case(5'h1D, 3'h1, 5'h0D, 5'h02, 5'h07, 5'h1F);
		g_case(5'h1D, 3'h3, 5'h05, 5'h02, 5'h17, 5'h1F);
		g_case(5'h1D, 3'h4, 5'h1F, 5'h00, 5'h1F, 5'h18);
		$display("test port g override done");
		for (int i = 0; i < 8; i++) begin
			s = 3'($urandom);
			@(posedge clk);
			{mem_ale, mem_rd, mem_wr} <= s;
			@(posedge clk);
			#1;
			`CHK("strobes", s, g_out[2:0])
		end
		$display("test memory strobes done");
		print_verdict;
	end
endmodule : tb_top
